// ### src/swc_top.sv
// sleep wake-up controller with axi4-lite register slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module swc_top (
  input wire logic clock,
  input wire logic reset_n,
  // axi4-lite slave
  input wire logic [swc_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [swc_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // always-on peripheral flags
  input wire swc_pkg::swc_flags_t flags,
  // pins
  input wire logic ext_irq_zero,
  input wire logic ext_irq_one,
  input wire logic uart_rx,
  input wire logic ext_reset_pin_n,
  // core and power control
  output logic core_sleep,
  output logic core_restart,
  output logic wake_to_battery,
  output logic power_mgmt_vector,
  output logic rtc_vector,
  output logic io_force_input,
  output logic lcd_enable,
  output logic lcd_mem_hold,
  output logic [23:0] pullup_enable
);
  // register storage
  logic [7:0] rtc_config_two_r;
  logic [7:0] pullup_r [3];
  logic [7:0] power_irq_enable_r;
  logic [7:0] temp_supply_delta_r;
  logic [1:0] rx_pin_prog_r;
  logic rx_edge_flag_r;
  logic lcd_sleep_on_r;
  logic [7:0] irq_prog_r;
  logic [7:0] timer_control_r;
  logic [7:0] sleep_scratch_regs_r [swc_pkg::SCRATCH_N];
  swc_pkg::swc_cause_t cause_r;
  swc_pkg::swc_state_t state_r;
  swc_pkg::swc_state_t state_nxt;

  // axi write path
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] wr_idx_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  // axi read path
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // decode helpers
  logic wr_go;
  logic wr_en;
  logic wr_hit;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic rd_hit;

  // pin sync outputs
  logic [3:0] pin_q;
  logic [3:0] pin_fall;
  logic [3:0] pin_rise;

  // wake sources
  swc_pkg::swc_cause_t src;
  logic wake_req;
  logic sleep_cmd;
  logic irq0_evt;
  logic irq1_evt;
  logic rx_edge;

  // pins cross into the clock domain first
  swc_sync #(.W(4), .RST_VAL(1'b1)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .d({ext_reset_pin_n, uart_rx, ext_irq_one, ext_irq_zero}),
    .q(pin_q),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // handshakes: one write and one read in flight
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // write fires once address and data are both held
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  // core is off while asleep, so bus writes are dropped
  assign wr_en = wr_go && wstrb0_r && (state_r == swc_pkg::ST_ACTIVE);
  assign sleep_cmd = wr_en && (wr_idx_r == swc_pkg::IDX_PWR_CTRL) &&
                     wdata_r[swc_pkg::PCTL_SLEEP_BIT];

  // write address and data capture, in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      wr_idx_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      // address taken
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        wr_idx_r <= s_axi_awaddr[swc_pkg::AW-1:2];
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      // data taken
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  // write response one cycle after both parts held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_r <= 1'b0;
      bresp_r <= swc_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // write decode: is the held index mapped
  always_comb begin
    if (wr_idx_r == swc_pkg::IDX_RTC_CFG2) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r >= swc_pkg::IDX_PU0 &&
                 wr_idx_r <= swc_pkg::IDX_PU2) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r == swc_pkg::IDX_PWR_CTRL ||
                 wr_idx_r == swc_pkg::IDX_PWR_IRQ_EN ||
                 wr_idx_r == swc_pkg::IDX_TSD ||
                 wr_idx_r == swc_pkg::IDX_PERIPHERAL_CONFIG_CFG ||
                 wr_idx_r == swc_pkg::IDX_IRQ_PROG ||
                 wr_idx_r == swc_pkg::IDX_TIMER_CTRL ||
                 wr_idx_r == swc_pkg::IDX_WAKE_STAT) begin
      wr_hit = 1'b1;
    end else if (wr_idx_r >= swc_pkg::IDX_SCRATCH0 &&
                 wr_idx_r < swc_pkg::IDX_IRQ_PROG) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // plain configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rtc_config_two_r <= swc_pkg::RST_BYTE;
      power_irq_enable_r <= swc_pkg::RST_BYTE;
      temp_supply_delta_r <= swc_pkg::RST_BYTE;
      rx_pin_prog_r <= 2'h0;
      lcd_sleep_on_r <= 1'b0;
      irq_prog_r <= swc_pkg::RST_BYTE;
      timer_control_r <= swc_pkg::RST_BYTE;
    end else if (wr_en) begin
      if (wr_idx_r == swc_pkg::IDX_RTC_CFG2) begin
        rtc_config_two_r <= wdata_r;
      end else if (wr_idx_r == swc_pkg::IDX_PWR_IRQ_EN) begin
        power_irq_enable_r <= wdata_r;
      end else if (wr_idx_r == swc_pkg::IDX_TSD) begin
        temp_supply_delta_r <= wdata_r;
      end else if (wr_idx_r == swc_pkg::IDX_PERIPHERAL_CONFIG_CFG) begin
        rx_pin_prog_r <= wdata_r[1:0];
      end else if (wr_idx_r == swc_pkg::IDX_PWR_CTRL) begin
        lcd_sleep_on_r <= wdata_r[swc_pkg::PCTL_LCD_BIT];
      end else if (wr_idx_r == swc_pkg::IDX_IRQ_PROG) begin
        irq_prog_r <= wdata_r;
      end else if (wr_idx_r == swc_pkg::IDX_TIMER_CTRL) begin
        timer_control_r <= wdata_r;
      end
    end
  end

  // per-port pull-up and scratch storage, one entry per word
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pu
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          pullup_r[gi] <= swc_pkg::RST_PULLUP;
        end else if (wr_en &&
                     wr_idx_r == swc_pkg::IDX_PU0 + 8'(gi)) begin
          pullup_r[gi] <= wdata_r;
        end
      end
      assign pullup_enable[gi*8 +: 8] = pullup_r[gi];
    end
    for (gi = 0; gi < swc_pkg::SCRATCH_N; gi++) begin : g_scr
      // written only while awake, so held in sleep
      always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
          sleep_scratch_regs_r[gi] <= swc_pkg::RST_BYTE;
        end else if (wr_en &&
                     wr_idx_r == swc_pkg::IDX_SCRATCH0 + 8'(gi)) begin
          sleep_scratch_regs_r[gi] <= wdata_r;
        end
      end
    end
  endgenerate

  // pin interrupt wake terms
  always_comb begin
    // select 1 wakes on falling edge, 0 on low level
    if (timer_control_r[swc_pkg::TC_IRQ0_SEL_BIT]) begin
      irq0_evt = pin_fall[0];
    end else begin
      irq0_evt = !pin_q[0];
    end
    // same edge choice for interrupt one
    if (timer_control_r[swc_pkg::TC_IRQ1_SEL_BIT]) begin
      irq1_evt = pin_fall[1];
    end else begin
      irq1_evt = !pin_q[1];
    end
  end

  assign rx_edge = pin_rise[2] || pin_fall[2];

  // rx edge flag: set wins over write-one-to-clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rx_edge_flag_r <= 1'b0;
    end else if (rx_edge && rx_pin_prog_r == swc_pkg::RX_PROG_WAKE) begin
      rx_edge_flag_r <= 1'b1;
    end else if (wr_en && wr_idx_r == swc_pkg::IDX_PERIPHERAL_CONFIG_CFG &&
                 wdata_r[swc_pkg::PC_RX_FLAG_BIT]) begin
      rx_edge_flag_r <= 1'b0;
    end
  end

  // gather each wake source after its enable; power restore, rtc interval and reset pin have no enable
  always_comb begin
    src.temp = flags.temp_meas_flag &&
               temp_supply_delta_r[swc_pkg::TSD_TEMP_EN_BIT];
    // supply gated by its wake enable
    src.supply = flags.supply_meas_flag &&
                 power_irq_enable_r[swc_pkg::PIE_SUPPLY_BIT];
    src.power_restored = flags.main_supply_active;
    src.rtc = flags.rtc_interval_flag ||
              |(flags.rtc_alarm & rtc_config_two_r[swc_pkg::ALARM_N-1:0]);
    src.irq0 = irq0_evt && irq_prog_r[swc_pkg::IP_IRQ0_BIT];
    src.irq1 = irq1_evt &&
               irq_prog_r[swc_pkg::IP_IRQ1_LSB+1 +: 2] ==
               swc_pkg::IRQ1_PROG_WAKE;
    src.rx_edge = rx_edge_flag_r;
    src.reset_pin = !pin_q[3];
  end

  // wake is the OR of all gated sources
  assign wake_req = |src;

  // sleep sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swc_pkg::ST_ACTIVE: begin
        if (sleep_cmd) begin
          state_nxt = swc_pkg::ST_SLEEP;
        end
      end
      swc_pkg::ST_SLEEP: begin
        // level sources still high wake at once
        if (wake_req) begin
          state_nxt = swc_pkg::ST_WAKE;
        end
      end
      swc_pkg::ST_WAKE: begin
        state_nxt = swc_pkg::ST_ACTIVE;
      end
      default: begin
        state_nxt = swc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= swc_pkg::ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake cause capture, cleared when sleep starts
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cause_r <= '0;
    end else if (sleep_cmd) begin
      cause_r <= '0;
    end else if (state_r == swc_pkg::ST_SLEEP && wake_req) begin
      cause_r <= src;
    end
  end

  // core control outputs, registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      core_restart <= 1'b0;
      wake_to_battery <= 1'b0;
      power_mgmt_vector <= 1'b0;
      rtc_vector <= 1'b0;
    end else begin
      // restart from reset vector on every wake
      core_restart <= state_r == swc_pkg::ST_SLEEP && wake_req;
      // reset wake lands in battery mode
      wake_to_battery <= state_r == swc_pkg::ST_SLEEP && wake_req &&
                         !src.power_restored;
      power_mgmt_vector <= state_r == swc_pkg::ST_SLEEP &&
                           (src.power_restored || src.supply);
      // rtc wake raises the rtc vector
      rtc_vector <= state_r == swc_pkg::ST_SLEEP && src.rtc;
    end
  end

  // pins forced to inputs while asleep
  assign core_sleep = state_r != swc_pkg::ST_ACTIVE;
  assign io_force_input = core_sleep;
  // lcd optionally left on, memory held in sleep
  assign lcd_enable = !core_sleep || lcd_sleep_on_r;
  assign lcd_mem_hold = core_sleep;

  // read decode and data select
  assign rd_idx = s_axi_araddr[swc_pkg::AW-1:2];
  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (rd_idx == swc_pkg::IDX_RTC_CFG2) begin
      rd_val = rtc_config_two_r;
    end else if (rd_idx == swc_pkg::IDX_PU0) begin
      rd_val = pullup_r[0];
    end else if (rd_idx == swc_pkg::IDX_PU1) begin
      rd_val = pullup_r[1];
    end else if (rd_idx == swc_pkg::IDX_PU2) begin
      rd_val = pullup_r[2];
    end else if (rd_idx == swc_pkg::IDX_PWR_CTRL) begin
      rd_val[swc_pkg::PCTL_LCD_BIT] = lcd_sleep_on_r;
    end else if (rd_idx == swc_pkg::IDX_PWR_IRQ_EN) begin
      rd_val = power_irq_enable_r;
    end else if (rd_idx == swc_pkg::IDX_TSD) begin
      rd_val = temp_supply_delta_r;
    end else if (rd_idx == swc_pkg::IDX_PERIPHERAL_CONFIG_CFG) begin
      rd_val[1:0] = rx_pin_prog_r;
      rd_val[swc_pkg::PC_MAIN_SUP_BIT] = flags.main_supply_active;
      rd_val[swc_pkg::PC_RX_FLAG_BIT] = rx_edge_flag_r;
    end else if (rd_idx == swc_pkg::IDX_IRQ_PROG) begin
      rd_val = irq_prog_r;
    end else if (rd_idx == swc_pkg::IDX_TIMER_CTRL) begin
      rd_val = timer_control_r;
    end else if (rd_idx == swc_pkg::IDX_WAKE_STAT) begin
      rd_val = cause_r;
    end else if (rd_idx >= swc_pkg::IDX_SCRATCH0 &&
                 rd_idx < swc_pkg::IDX_IRQ_PROG) begin
      rd_val = sleep_scratch_regs_r[2'(rd_idx - swc_pkg::IDX_SCRATCH0)];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // read response one cycle after address taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= swc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_val};
      rresp_r <= rd_hit ? swc_pkg::RESP_OKAY : swc_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule : swc_top

// ### src/swc_pkg.sv
// constants and types for the sleep wake-up controller
// Function
// - temperature flag wakes unless measurements disabled
// - supply flag wakes when its enable set
// - main power restore always wakes, unmaskable
// - peripheral config bit 6 shows main supply
// - rtc interval wakes; firmware acknowledges it
// - rtc alarm wakes per alarm enable bits
// - interrupt zero wakes when program equals 1
// - interrupt one wakes when program equals 11x
// - rx edge wakes, sets flag bit 7
// - reset pin low wakes into battery mode
// - lcd selectable in sleep, memory kept
// - four scratch registers kept through sleep
// - all pins inputs in sleep
// - per-pin pull-up disable, three port registers
// - wake restarts core at reset vector
package swc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RTC_CFG2 = 8'hA2;
  localparam logic [7:0] IDX_PU0 = 8'hB2;
  localparam logic [7:0] IDX_PU1 = 8'hB3;
  localparam logic [7:0] IDX_PU2 = 8'hB4;
  localparam logic [7:0] IDX_PWR_CTRL = 8'hC5;
  localparam logic [7:0] IDX_PWR_IRQ_EN = 8'hEC;
  localparam logic [7:0] IDX_TSD = 8'hF3;
  localparam logic [7:0] IDX_PERIPHERAL_CONFIG_CFG = 8'hF4;
  localparam logic [7:0] IDX_SCRATCH0 = 8'hFB;
  localparam logic [7:0] IDX_IRQ_PROG = 8'hFF;
  localparam logic [7:0] IDX_TIMER_CTRL = 8'h88;
  localparam logic [7:0] IDX_WAKE_STAT = 8'h80;
  localparam int SCRATCH_N = 4;
  // address bus width in bits
  localparam int AW = 10;

  // field positions
  localparam int TSD_TEMP_EN_BIT = 0;
  localparam int PIE_SUPPLY_BIT = 0;
  localparam int PC_RX_FLAG_BIT = 7;
  localparam int PC_MAIN_SUP_BIT = 6;
  localparam int PCTL_SLEEP_BIT = 4;
  localparam int PCTL_LCD_BIT = 0;
  localparam int TC_IRQ0_SEL_BIT = 0;
  localparam int TC_IRQ1_SEL_BIT = 2;
  localparam int IP_IRQ0_BIT = 0;
  localparam int IP_IRQ1_LSB = 1;
  localparam int ALARM_N = 2;

  // field values
  localparam logic [1:0] RX_PROG_WAKE = 2'h3;
  localparam logic [1:0] IRQ1_PROG_WAKE = 2'h3;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_PULLUP = 8'hFF;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sleep sequencer states
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAKE
  } swc_state_t;

  // level flags from the always-on peripherals
  typedef struct packed {
    logic temp_meas_flag;
    logic supply_meas_flag;
    logic main_supply_active;
    logic rtc_interval_flag;
    logic [ALARM_N-1:0] rtc_alarm;
  } swc_flags_t;

  // wake cause record, one bit per source
  typedef struct packed {
    logic reset_pin;
    logic rx_edge;
    logic irq1;
    logic irq0;
    logic rtc;
    logic power_restored;
    logic supply;
    logic temp;
  } swc_cause_t;
endpackage : swc_pkg

// ### src/swc_sync.sv
// two-stage synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module swc_sync #(
  parameter int W = 1,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] s1_r; // first stage, read only by s2_r
  logic [W-1:0] s2_r; // synchronised level
  logic [W-1:0] s3_r; // delayed copy for edges

  // sync chain and delay stage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_r <= {W{RST_VAL}};
      s2_r <= {W{RST_VAL}};
      s3_r <= {W{RST_VAL}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign q = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule : swc_sync

// ### sim/swc_top_asserts.sv
// port assertions for the sleep wake-up controller
`timescale 1ns/1ps
module swc_top_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire swc_pkg::swc_flags_t flags,
  input wire logic ext_reset_pin_n,
  input wire logic core_sleep,
  input wire logic core_restart,
  input wire logic wake_to_battery,
  input wire logic power_mgmt_vector,
  input wire logic rtc_vector,
  input wire logic io_force_input,
  input wire logic lcd_enable,
  input wire logic lcd_mem_hold
);
  // one clock domain, reset gates everything
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_pins_input: assert property (
    io_force_input == core_sleep) else $error("pins not inputs in sleep");
  a_lcd_hold: assert property (
    (lcd_mem_hold == core_sleep) && (core_sleep || lcd_enable))
    else $error("lcd memory hold or enable wrong");
  a_restart_pulse: assert property (
    core_restart |=> !core_restart) else $error("restart longer than one");
  a_restart_exit: assert property (
    core_restart |-> core_sleep ##1 !core_sleep)
    else $error("restart without leaving sleep");
  a_reset_pin_wake: assert property (
    core_sleep && $fell(ext_reset_pin_n) |-> ##[0:8] core_restart)
    else $error("reset pin did not wake");
  a_restore_wake: assert property (
    core_sleep && flags.main_supply_active |-> ##[0:4] core_restart)
    else $error("power restore did not wake");
  a_battery_wake: assert property (
    wake_to_battery |-> core_restart) else $error("battery wake alone");
  a_pmv_cause: assert property (
    power_mgmt_vector |->
      $past(flags.main_supply_active || flags.supply_meas_flag))
    else $error("power vector without cause");
  a_rtc_cause: assert property (
    rtc_vector |-> $past(flags.rtc_interval_flag || (|flags.rtc_alarm)))
    else $error("rtc vector without cause");
endmodule : swc_top_asserts

// ### sim/swc_core_model.sv
// core and firmware model: axi4-lite master and sleep command
`timescale 1ns/1ps
module swc_core_model (
  input wire logic clock,
  output logic [swc_pkg::AW-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [swc_pkg::AW-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // idle bus from time zero
  initial begin
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end
  // one write, each channel released when taken
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    output logic [1:0] resp);
    @(posedge clock);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read, data taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic sleep(input logic lcd);
    logic [1:0] r;
    wr(swc_pkg::IDX_PWR_CTRL, {3'h0, 1'b1, 3'h0, lcd}, r);
  endtask : sleep
endmodule : swc_core_model

// ### sim/test_sleep_wakeup_controller.sv
// self-checking bench for the sleep wake-up controller
`timescale 1ns/1ps
module test_sleep_wakeup_controller;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [swc_pkg::AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  swc_pkg::swc_flags_t flags = '0;
  logic ext_irq_zero = 1'b1;
  logic ext_irq_one = 1'b1;
  logic uart_rx = 1'b1;
  logic ext_reset_pin_n = 1'b1;
  logic core_sleep, core_restart, wake_to_battery, power_mgmt_vector;
  logic rtc_vector, io_force_input, lcd_enable, lcd_mem_hold;
  logic [23:0] pullup_enable;
  logic batt_seen = 1'b0;
  logic [1:0] vec_seen = 2'h0; // power and rtc vectors at the last wake
  int restarts = 0;
  int bad_count = 0;
  int samples_checked = 0;

  // 25 MHz clock
  always #20 clock = ~clock;

  swc_top u_swc_top (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flags, .ext_irq_zero,
    .ext_irq_one, .uart_rx, .ext_reset_pin_n, .core_sleep, .core_restart,
    .wake_to_battery, .power_mgmt_vector, .rtc_vector, .io_force_input,
    .lcd_enable, .lcd_mem_hold, .pullup_enable);

  swc_core_model u_swc_core_model (.clock, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // count wake pulses and keep the battery indication
  always @(posedge clock) begin
    if (core_restart) begin
      restarts <= restarts + 1;
      batt_seen <= wake_to_battery;
      vec_seen <= {power_mgmt_vector, rtc_vector};
    end
  end

  // value compare
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // status bit recorded for each source
  function automatic int cause_bit(input int s);
    return (s < 4) ? s : s - 1;
  endfunction : cause_bit

  // raise or drop one wake source; 7 gives an rx edge
  task automatic drive_src(input int s, input logic v);
    @(posedge clock);
    case (s)
      0: flags.temp_meas_flag <= v;
      1: flags.supply_meas_flag <= v;
      2: flags.main_supply_active <= v;
      3: flags.rtc_interval_flag <= v;
      4: flags.rtc_alarm <= v ? 2'(1 << $urandom_range(1, 0)) : 2'h0;
      5: ext_irq_zero <= !v;
      6: ext_irq_one <= !v;
      7: if (v) uart_rx <= !uart_rx;
      default: ext_reset_pin_n <= !v;
    endcase
  endtask : drive_src

  // one sleep with a source enabled or masked
  task automatic run(input int s, input logic en);
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] sv;
    logic lcd;
    logic tsel;
    int c0;
    sv = 8'($urandom);
    lcd = 1'($urandom);
    // pin interrupts on falling edge or on low level
    tsel = 1'($urandom);
    u_swc_core_model.wr(swc_pkg::IDX_TSD, {7'h0, en}, r);
    u_swc_core_model.wr(swc_pkg::IDX_PWR_IRQ_EN, {7'h0, en}, r);
    u_swc_core_model.wr(swc_pkg::IDX_RTC_CFG2, {6'h0, en, en}, r);
    u_swc_core_model.wr(swc_pkg::IDX_IRQ_PROG, en ? 8'h0D : 8'h08, r);
    u_swc_core_model.wr(swc_pkg::IDX_TIMER_CTRL,
                        {5'h0, tsel, 1'b0, tsel}, r);
    u_swc_core_model.wr(swc_pkg::IDX_PERIPHERAL_CONFIG_CFG, {6'h20, en, 1'b1}, r);
    u_swc_core_model.wr(swc_pkg::IDX_SCRATCH0 + 8'(s % 4), sv, r);
    if (s == 0) drive_src(s, 1'b1);
    c0 = restarts;
    u_swc_core_model.sleep(lcd);
    @(posedge clock);
    #1;
    if (s != 0) chk("lcd in sleep", {31'h0, lcd}, {31'h0, lcd_enable});
    if (s != 0) chk("sleep hold", 32'h0000_0003,
                    {30'h0, io_force_input, lcd_mem_hold});
    if (s != 0) drive_src(s, 1'b1);
    repeat (20) @(posedge clock);
    #1;
    chk("wake", {31'h0, en}, {31'h0, restarts != c0});
    if (en) chk("battery", {31'h0, s != 2}, {31'h0, batt_seen});
    if (!en) begin
      drive_src(s, 1'b0);
      drive_src(8, 1'b1);
      repeat (20) @(posedge clock);
    end
    // vectors raised with the wake pulse
    chk("vectors", {30'h0, en && (s inside {1, 2}), en && (s inside {3, 4})},
        {30'h0, vec_seen});
    u_swc_core_model.rd(swc_pkg::IDX_PERIPHERAL_CONFIG_CFG, d, r);
    chk("main supply", {31'h0, s == 2}, {31'h0, d[6]});
    chk("rx flag", {31'h0, s == 7 && en}, {31'h0, d[7]});
    drive_src(s, 1'b0);
    drive_src(8, 1'b0);
    u_swc_core_model.rd(swc_pkg::IDX_WAKE_STAT, d, r);
    chk("cause", {31'h0, en}, {31'h0, d[cause_bit(s)]});
    u_swc_core_model.rd(swc_pkg::IDX_SCRATCH0 + 8'(s % 4), d, r);
    chk("scratch", {24'h0, sv}, d);
  endtask : run

  // main sequence
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] pu [3];
    void'($urandom(66323));
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    chk("pullup reset", 32'hFFFFFF, {8'h0, pullup_enable});
    for (int i = 0; i < 3; i++) begin
      pu[i] = 8'($urandom);
      u_swc_core_model.wr(swc_pkg::IDX_PU0 + 8'(i), pu[i], r);
    end
    @(posedge clock);
    #1;
    chk("pullup", {8'h0, pu[2], pu[1], pu[0]}, {8'h0, pullup_enable});
    u_swc_core_model.rd(swc_pkg::IDX_PU1, d, r);
    chk("pullup read", {24'h0, pu[1]}, d);
    u_swc_core_model.rd(8'h10, d, r);
    chk("unmapped", {30'h0, swc_pkg::RESP_SLVERR}, {30'h0, r});
    for (int s = 0; s < 9; s++) begin
      for (int e = 0; e < 2; e++) begin
        if (e == 1 || !(s inside {2, 3, 8})) run(s, 1'(e));
      end
    end
    final_report();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    final_report();
  end
endmodule : test_sleep_wakeup_controller

bind swc_top swc_top_asserts u_swc_top_asserts (.clock, .reset_n, .flags,
  .ext_reset_pin_n, .core_sleep, .core_restart, .wake_to_battery,
  .power_mgmt_vector, .rtc_vector, .io_force_input, .lcd_enable,
  .lcd_mem_hold);
